/* File: hdl/cise_core.sv */
// execution core for the instruction subset
// Overview of operation
// - increment-and-skip adds one, flags untouched
// - zero result discards prefetched word, runs nop
// - destination bit 0 accumulator, 1 file
// - jump loads pc 8:0, page from status
// - jump always takes two cycles
// - or-literal into accumulator, zero flag only
// - or-file to destination, zero flag only
// - store accumulator to file, flags untouched
// - copy file to destination, zero flag
// - load literal into accumulator, flags untouched
// - load option register from accumulator
// - call pushes return, clears pc bit 8
`timescale 1ns/1ps
`default_nettype none
module cise_core #(
  parameter int STACK_DEPTH = 2
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic [cise_pkg::INSTR_W-1:0]  instr_in,
  output logic      [cise_pkg::PC_W-1:0]     pc_out,
  output logic      [cise_pkg::DATA_W-1:0]   acc_out,
  output logic      [cise_pkg::DATA_W-1:0]   status_out,
  output logic      [cise_pkg::DATA_W-1:0]   option_out,
  output logic                               discard_out
);
  import cise_pkg::*;

  // the stack needs at least one entry, and the target concatenations only fit these field widths
  if (STACK_DEPTH < 1) begin : g_bad_stack_depth
    $error("cise_core: STACK_DEPTH must be at least 1");
  end
  if (PC_W != JUMP_W + PAGE_HI - PAGE_LO + 1) begin : g_bad_pc_width
    $error("cise_core: pc width must equal jump target plus page bits");
  end
  if (JUMP_W != CALL_W + 1) begin : g_bad_call_width
    $error("cise_core: call target must be one bit below jump target");
  end

  typedef struct packed {
    logic [PC_W-1:0]                      pc;
    logic [DATA_W-1:0]                    acc;
    logic [DATA_W-1:0]                    status;
    logic [DATA_W-1:0]                    option;
    logic                                 discard;
    logic [FILE_DEPTH-1:0][DATA_W-1:0]    file;
    logic [STACK_DEPTH-1:0][PC_W-1:0]     stack;
  } cise_state_t;

  cise_state_t state_reg;
  cise_state_t state_next;

  // first word after reset is stale, so it is discarded
  localparam cise_state_t STATE_RESET = '{
    pc:      PC_RESET,
    acc:     ACC_RESET,
    status:  STATUS_RESET,
    option:  OPTION_RESET,
    discard: 1'b1,
    file:    {FILE_DEPTH{FILE_RESET}},
    stack:   {STACK_DEPTH{PC_RESET}}
  };

  // one-hot class of the word in flight
  typedef enum logic [10:0] {
    CISE_K_IDLE   = 11'h001,
    CISE_K_STORE  = 11'h002,
    CISE_K_ORF    = 11'h004,
    CISE_K_COPY   = 11'h008,
    CISE_K_INC    = 11'h010,
    CISE_K_JUMP   = 11'h020,
    CISE_K_CALL   = 11'h040,
    CISE_K_LIT    = 11'h080,
    CISE_K_ORL    = 11'h100,
    CISE_K_OPTION = 11'h200,
    CISE_K_FLUSH  = 11'h400
  } cise_kind_t;

  function automatic logic op_match(input logic [INSTR_W-1:0] word,
                                    input logic [INSTR_W-1:0] mask,
                                    input logic [INSTR_W-1:0] pattern);
    op_match = ((word & mask) == pattern);
  endfunction

  // a flushed slot wins over whatever opcode it holds
  function automatic cise_kind_t decode_kind(
    input logic [INSTR_W-1:0] word,
    input logic               flushing
  );
    if (flushing) begin
      decode_kind = CISE_K_FLUSH;
    end else if (op_match(word, MASK_FILE, OP_STORE_ACC_TO_FILE)) begin
      decode_kind = CISE_K_STORE;
    end else if (op_match(word, MASK_DF, OP_OR_ACC_FILE)) begin
      decode_kind = CISE_K_ORF;
    end else if (op_match(word, MASK_DF, OP_COPY_FILE)) begin
      decode_kind = CISE_K_COPY;
    end else if (op_match(word, MASK_DF, OP_INC_SKIP_IF_NULL)) begin
      decode_kind = CISE_K_INC;
    end else if (op_match(word, MASK_JUMP, OP_JUMP_ABSOLUTE)) begin
      decode_kind = CISE_K_JUMP;
    end else if (op_match(word, MASK_LIT, OP_CALL)) begin
      decode_kind = CISE_K_CALL;
    end else if (op_match(word, MASK_LIT, OP_LOAD_LITERAL_ACC)) begin
      decode_kind = CISE_K_LIT;
    end else if (op_match(word, MASK_LIT, OP_OR_LITERAL_ACC)) begin
      decode_kind = CISE_K_ORL;
    end else if (op_match(word, MASK_ALL, OP_LOAD_OPTION)) begin
      decode_kind = CISE_K_OPTION;
    end else begin
      // nop and every word outside the subset
      decode_kind = CISE_K_IDLE;
    end
  endfunction

  // destination bit picks accumulator or the addressed file entry
  function automatic cise_state_t route_result(
    input cise_state_t        s,
    input logic               to_file,
    input logic [FADDR_W-1:0] addr,
    input logic [DATA_W-1:0]  value
  );
    route_result = s;
    if (to_file) begin
      route_result.file[addr] = value;
    end else begin
      route_result.acc = value;
    end
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    is_zero = (value == DATA_ZERO);
  endfunction

  logic [FADDR_W-1:0] faddr;
  logic [DATA_W-1:0]  fval;
  logic [DATA_W-1:0]  literal;
  logic               dest_file;
  logic [DATA_W-1:0]  result;
  cise_kind_t         instr_kind;
  wire logic [STACK_DEPTH-1:0][PC_W-1:0] stack_pushed;

  assign faddr     = instr_in[FADDR_W-1:0];
  assign fval      = state_reg.file[faddr];
  assign literal   = instr_in[DATA_W-1:0];
  assign dest_file = instr_in[DEST_BIT];
  assign instr_kind = decode_kind(instr_in, state_reg.discard);

  // return address lands on top, deeper entries move down one
  assign stack_pushed[0] = state_reg.pc;
  for (genvar g = 1; g < STACK_DEPTH; g++) begin : g_stack_shift
    assign stack_pushed[g] = state_reg.stack[g-1];
  end

  always_comb begin
    state_next         = state_reg;
    result             = DATA_ZERO;
    // every instruction advances the pc unless it redirects
    state_next.pc      = state_reg.pc + PC_ONE;
    state_next.discard = 1'b0;
    case (instr_kind)
      CISE_K_FLUSH: begin
        // prefetched word thrown away, a nop runs in its slot
        result = DATA_ZERO;
      end
      CISE_K_STORE: begin
        state_next.file[faddr] = state_reg.acc;
      end
      CISE_K_ORF: begin
        result     = state_reg.acc | fval;
        state_next = route_result(state_next, dest_file, faddr, result);
        state_next.status[Z_BIT] = is_zero(result);
      end
      CISE_K_COPY: begin
        result     = fval;
        state_next = route_result(state_next, dest_file, faddr, result);
        state_next.status[Z_BIT] = is_zero(result);
      end
      CISE_K_INC: begin
        // status untouched: the skip stands in for a zero flag
        result     = fval + DATA_ONE;
        state_next = route_result(state_next, dest_file, faddr, result);
        state_next.discard = is_zero(result);
      end
      CISE_K_JUMP: begin
        state_next.pc      = {state_reg.status[PAGE_HI:PAGE_LO],
                              instr_in[JUMP_W-1:0]};
        state_next.discard = 1'b1;
      end
      CISE_K_CALL: begin
        // oldest entry falls off when the stack is full
        state_next.stack   = stack_pushed;
        state_next.pc      = {state_reg.status[PAGE_HI:PAGE_LO], 1'b0,
                              instr_in[CALL_W-1:0]};
        state_next.discard = 1'b1;
      end
      CISE_K_LIT: begin
        state_next.acc = literal;
      end
      CISE_K_ORL: begin
        result         = state_reg.acc | literal;
        state_next.acc = result;
        state_next.status[Z_BIT] = is_zero(result);
      end
      CISE_K_OPTION: begin
        state_next.option = state_reg.acc;
      end
      default: begin
        // nop and every word outside the subset only advance the pc
        result = DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pc_out      = state_reg.pc;
  assign acc_out     = state_reg.acc;
  assign status_out  = state_reg.status;
  assign option_out  = state_reg.option;
  assign discard_out = state_reg.discard;
endmodule : cise_core
`default_nettype wire

/* File: pkg/cise_pkg.sv */
// constants and opcode patterns for the instruction subset executor
package cise_pkg;
  localparam int INSTR_W    = 12;
  localparam int DATA_W     = 8;
  localparam int PC_W       = 11;
  localparam int FADDR_W    = 5;
  localparam int FILE_DEPTH = 32;
  localparam int JUMP_W     = 9;
  localparam int CALL_W     = 8;

  // field positions inside an instruction word
  localparam int DEST_BIT = 5;
  // field positions inside the status register
  localparam int Z_BIT   = 2;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 5;

  // reset values, then the one and zero constants
  localparam logic [PC_W-1:0]   PC_RESET     = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] FILE_RESET   = 8'h00;
  localparam logic [PC_W-1:0]   PC_ONE       = 11'h001;
  localparam logic [DATA_W-1:0] DATA_ONE     = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO    = 8'h00;

  // opcode masks and match values
  localparam logic [INSTR_W-1:0] MASK_ALL  = 12'hFFF;
  localparam logic [INSTR_W-1:0] MASK_FILE = 12'hFE0;
  localparam logic [INSTR_W-1:0] MASK_DF   = 12'hFC0;
  localparam logic [INSTR_W-1:0] MASK_JUMP = 12'hE00;
  localparam logic [INSTR_W-1:0] MASK_LIT  = 12'hF00;

  localparam logic [INSTR_W-1:0] OP_NOP               = 12'h000;
  localparam logic [INSTR_W-1:0] OP_LOAD_OPTION       = 12'h002;
  localparam logic [INSTR_W-1:0] OP_STORE_ACC_TO_FILE = 12'h020;
  localparam logic [INSTR_W-1:0] OP_OR_ACC_FILE       = 12'h100;
  localparam logic [INSTR_W-1:0] OP_COPY_FILE         = 12'h200;
  localparam logic [INSTR_W-1:0] OP_INC_SKIP_IF_NULL  = 12'h3C0;
  localparam logic [INSTR_W-1:0] OP_CALL              = 12'h900;
  localparam logic [INSTR_W-1:0] OP_JUMP_ABSOLUTE     = 12'hA00;
  localparam logic [INSTR_W-1:0] OP_LOAD_LITERAL_ACC  = 12'hC00;
  localparam logic [INSTR_W-1:0] OP_OR_LITERAL_ACC    = 12'hD00;
endpackage : cise_pkg

/* File: verification/cise_core_properties.sv */
// port assertions for the instruction subset executor
`timescale 1ns/1ps
`default_nettype none
module cise_core_properties #(parameter int STACK_DEPTH = 2) (
  input wire logic                         sys_clk_in,
  input wire logic                         reset_n_in,
  input wire logic [cise_pkg::INSTR_W-1:0] instr_in,
  input wire logic [cise_pkg::PC_W-1:0]    pc_out,
  input wire logic [cise_pkg::DATA_W-1:0]  acc_out,
  input wire logic [cise_pkg::DATA_W-1:0]  status_out,
  input wire logic [cise_pkg::DATA_W-1:0]  option_out,
  input wire logic                         discard_out
);
  import cise_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // a discarded word counts as a nop
  wire logic [INSTR_W-1:0] i = instr_in & {INSTR_W{!discard_out}};
  property p_lit;
    i[11:8] == 4'hC |=> acc_out == $past(i[7:0]) && $stable(status_out);
  endproperty
  a_lit: assert property (p_lit) else $error("literal load wrong");
  property p_orl;
    i[11:8] == 4'hD |=> acc_out == ($past(acc_out) | $past(i[7:0]))
      && status_out[Z_BIT] == (acc_out == DATA_ZERO);
  endproperty
  a_orl: assert property (p_orl) else $error("or literal wrong");
  property p_jump;
    i[11:9] == 3'h5 |=> pc_out == {$past(status_out[PAGE_HI:PAGE_LO]),
      $past(i[8:0])};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_two;
    i[11:9] == 3'h5 |=> discard_out ##1 !discard_out;
  endproperty
  a_two: assert property (p_two) else $error("jump length wrong");
  property p_call;
    i[11:8] == 4'h9 |=> discard_out && pc_out[8:0] == {1'b0, $past(i[7:0])};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_opt;
    i == 12'h002 |=> option_out == $past(acc_out) && $stable(status_out);
  endproperty
  a_opt: assert property (p_opt) else $error("option load wrong");
  property p_nop;
    i == 12'h000 |=> pc_out == $past(pc_out) + PC_ONE && $stable(acc_out)
      && $stable(option_out) && $stable(status_out);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
  property p_skip;
    i[11:5] == 7'h1E |=> discard_out == (acc_out == DATA_ZERO)
      && $stable(status_out);
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  c_skip: cover property (i[11:6] == 6'h0F ##1 discard_out);
  c_jump: cover property (i[11:9] == 3'h5);
  c_zero: cover property (i[11:8] == 4'hD ##1 status_out[Z_BIT]);
endmodule // cise_core_properties
bind cise_core cise_core_properties #(.STACK_DEPTH(STACK_DEPTH)) i_props (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
  .pc_out(pc_out), .acc_out(acc_out), .status_out(status_out),
  .option_out(option_out), .discard_out(discard_out));
`default_nettype wire

/* File: verification/cpu_instr_subset_exec_test.sv */
// random and corner instruction streams against a reference model
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_subset_exec_test;
  import cise_pkg::*;
  logic               sys_clk_in = 1'b0;
  logic               reset_n_in;
  logic [INSTR_W-1:0] instr_in = 12'h000;
  logic [PC_W-1:0]    pc_out, m_pc;
  logic [DATA_W-1:0]  acc_out, status_out, option_out, m_acc, m_opt, r;
  logic [DATA_W-1:0]  m_file [FILE_DEPTH];
  logic               discard_out, m_z, m_dis;
  int                 failures = 0, checks_done = 0, n;
  int                 seed = 32'hCE3E665B;
  logic [INSTR_W-1:0] base [10] = '{12'h000, 12'h002, 12'h020, 12'h100,
    12'h200, 12'h3C0, 12'h900, 12'hA00, 12'hC00, 12'hD00};
  logic [INSTR_W-1:0] opm [10] = '{12'h000, 12'h000, 12'h01F, 12'h03F,
    12'h03F, 12'h03F, 12'h0FF, 12'h1FF, 12'h0FF, 12'h0FF};
  logic [INSTR_W-1:0] corner [14] = '{12'hC00, 12'hD00, 12'hCFF, 12'h023,
    12'h3E3, 12'hC55, 12'h203, 12'h3C3, 12'h002, 12'hBFF, 12'hC12, 12'h9AB,
    12'h000, 12'h223};
  cise_core i_cise_core (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .instr_in(instr_in), .pc_out(pc_out), .acc_out(acc_out),
    .status_out(status_out), .option_out(option_out),
    .discard_out(discard_out));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  task check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function void step(input logic [INSTR_W-1:0] w);
    logic [FADDR_W-1:0] f;
    f = w[4:0];
    r = m_file[f];
    m_pc = m_pc + PC_ONE;
    if (m_dis) begin
      m_dis = 1'b0;
      return;
    end
    if (w[11:6] == 6'h04 || w[11:6] == 6'h08 || w[11:6] == 6'h0F) begin
      if (w[11:6] == 6'h04) r = r | m_acc;
      if (w[11:6] == 6'h0F) r = r + DATA_ONE;
      if (w[DEST_BIT]) m_file[f] = r;
      else m_acc = r;
      if (w[11:6] == 6'h0F) m_dis = (r == DATA_ZERO);
      else m_z = (r == DATA_ZERO);
    end
    else if (w == 12'h002) m_opt = m_acc;
    else if (w[11:5] == 7'h01) m_file[f] = m_acc;
    else if (w[11:8] == 4'h9) {m_pc, m_dis} = {3'b000, w[7:0], 1'b1};
    else if (w[11:9] == 3'h5) {m_pc, m_dis} = {2'b00, w[8:0], 1'b1};
    else if (w[11:8] == 4'hC) m_acc = w[7:0];
    else if (w[11:8] == 4'hD) begin
      m_acc = m_acc | w[7:0];
      m_z = (m_acc == DATA_ZERO);
    end
  endfunction
  task check_all;
    check(pc_out, m_pc, "pc");
    check(acc_out, m_acc, "acc");
    check(status_out, {5'h00, m_z, 2'b00}, "status");
    check(option_out, m_opt, "option");
    check(discard_out, m_dis, "discard");
  endtask
  task run(input logic [INSTR_W-1:0] w);
    check_all();
    instr_in = w;
    step(w);
    @(negedge sys_clk_in);
  endtask
  // reset applied at a falling edge, outputs checked while it is held
  task do_reset(input int cycles);
    reset_n_in = 1'b0;
    {m_pc, m_acc, m_opt, m_z, m_dis} = {PC_RESET, ACC_RESET, OPTION_RESET,
      2'b01};
    foreach (m_file[k]) m_file[k] = FILE_RESET;
    repeat (cycles) @(negedge sys_clk_in);
    check_all();
    reset_n_in = 1'b1;
  endtask
  task finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    do_reset(16);
    foreach (corner[k]) run(corner[k]);
    do_reset(3);
    foreach (corner[k]) run(corner[k]);
    repeat (3000) begin
      n = $unsigned($random(seed)) % 10;
      run(base[n] | (opm[n] & 12'($random(seed))));
    end
    check_all();
    finish_test();
  end
endmodule // cpu_instr_subset_exec_test
`default_nettype wire
